// ### isg_far_slave.sv
`timescale 1ns/1ps
module isg_far_slave (
	// Far SPI lines
	input  wire logic       farSclk,
	input  wire logic       farSelB,
	input  wire logic       farMosi,
	output logic            farMiso,
	// Bench side
	input  wire logic [7:0] replyByte,
	output logic      [7:0] rxByte
);
	logic [7:0] shift_q;

	initial begin
		farMiso = 1'h0;
		rxByte  = 8'h00;
		shift_q = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// Mode 0 slave, answers only while selected
	always @(negedge farSelB) begin
		shift_q = replyByte;
		farMiso = replyByte[7];
	end
	always @(posedge farSclk) begin
		if (!farSelB) rxByte = {rxByte[6:0], farMosi};
	end
	always @(negedge farSclk) begin
		if (!farSelB) begin
			shift_q = {shift_q[6:0], 1'h0};
			farMiso = shift_q[7];
		end
	end
	// Released line flips, so a stale bit never looks valid
	always @(posedge farSelB) farMiso = ~farMiso;
endmodule // isg_far_slave

// ### isg_fifo.sv
`timescale 1ns/1ps
module isg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstB,
	// Both sides
	isg_fifo_if.store port
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wrPtr_q, wrPtr_d;
	logic [AW-1:0]    rdPtr_q, rdPtr_d;
	logic [AW:0]      cnt_q,   cnt_d;
	logic             push, pop;

	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign port.wrReady = (cnt_q != (AW+1)'(DEPTH));
	assign port.rdValid = (cnt_q != '0);
	assign port.rdData  = mem_q[rdPtr_q];
	assign push         = port.wrValid && port.wrReady;
	assign pop          = port.rdValid && port.rdReady;

	always_comb begin
		wrPtr_d = push ? nextPtr(wrPtr_q) : wrPtr_q;
		rdPtr_d = pop ? nextPtr(rdPtr_q) : rdPtr_q;
		cnt_d   = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstB) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			cnt_q   <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			cnt_q   <= cnt_d;
		end
	end

	// Storage needs no reset; count guards every read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wrPtr_q] <= port.wrData;
		end
	end
endmodule // isg_fifo

// ### isg_fifo_if.sv
`timescale 1ns/1ps
interface isg_fifo_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] wrData;
	logic             wrValid;
	logic             wrReady;
	logic [WIDTH-1:0] rdData;
	logic             rdValid;
	logic             rdReady;
	modport store (input wrData, input wrValid, output wrReady, output rdData, output rdValid, input rdReady);
	modport user  (output wrData, output wrValid, input wrReady, input rdData, input rdValid, output rdReady);
endinterface

// ### isg_pkg.sv
package isg_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int GP_WIDTH      = 3;
	// Wake-up latency after the select falls, rounded up to whole cycles
	localparam int WAKE_NS       = 100;
	localparam int WAKE_CYC      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_W        = $clog2(WAKE_CYC + 1);
	// 19.5 us peak jitter bounds one full round trip, rounded down
	localparam int JITTER_NS     = 19500;
	localparam int JITTER_CYC    = JITTER_NS / CLK_PERIOD_NS;
	localparam int SMP_CYC       = JITTER_CYC / 2;
	localparam int SMP_W         = $clog2(SMP_CYC + 1);
	localparam int FIFO_DEPTH    = 4;
	localparam logic DIR_TO_FAR  = 1'b0;
	localparam logic DIR_TO_HOST = 1'b1;
	localparam logic START_BIT   = 1'b1;
	localparam logic COIL_IDLE   = 1'b0;

	typedef enum logic [2:0] {
		LNK_SLEEP  = 3'b001,
		LNK_WAKE   = 3'b010,
		LNK_ACTIVE = 3'b100
	} isg_link_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b001,
		TX_SHIFT = 3'b010,
		TX_GAP   = 3'b100
	} isg_tx_t;
endpackage

// ### isg_spi_gpio_top.sv
// Behaviour
// - Forward clock, transmit data, select host to far; receive data far to host.
// - Forward channel levels unchanged, any SPI mode or polarity.
// - Select active low; channels sleep while high, active only while low.
// - Hold far outputs idle for wake latency after select falls.
// - Select high: far select high, outputs tristate; low: forward each signal.
// - Sample all inputs of one side together, pack, shift over one coil, alternate.
// - General outputs lag inputs by sampling jitter within stated peak.
// - Outputs low in startup; with both supplies up outputs follow inputs.
// - One supply drops: powered side holds outputs, losing side goes low.
`timescale 1ns/1ps
module isg_spi_gpio_top #(
	parameter int GP_W = isg_pkg::GP_WIDTH
) (
	// Clock and reset
	input  wire logic            core_clk,
	input  wire logic            rst_b,
	// Host SPI side
	input  wire logic            hostClockIn,
	input  wire logic            hostTxIn,
	input  wire logic            hostSelectIn,
	output logic                 hostRxOut,
	output logic                 hostRxOe,
	// Far SPI side
	output logic                 farClockOut,
	output logic                 farClockOe,
	output logic                 farTxOut,
	output logic                 farTxOe,
	output logic                 farSelectOut,
	input  wire logic            farRxIn,
	// General channels
	input  wire logic [GP_W-1:0] hostGpIn,
	input  wire logic [GP_W-1:0] farGpIn,
	output logic      [GP_W-1:0] hostGpOut,
	output logic      [GP_W-1:0] farGpOut,
	// Supply status
	input  wire logic            hostSupply,
	input  wire logic            farSupply
);
	import isg_pkg::*;

	localparam int PKT_W   = GP_W + 1;
	localparam int FRAME_W = GP_W + 3;
	localparam int FCNT_W  = $clog2(FRAME_W + 1);
	localparam int BIT_CYC = (SMP_CYC / (2 * (FRAME_W + 1)) > 0) ? SMP_CYC / (2 * (FRAME_W + 1)) : 1;
	localparam int BIT_W   = $clog2(BIT_CYC + 1);

	function automatic logic parityOf(input logic [PKT_W-1:0] v);
		return ^v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Synchronisers: first stage is read only by the second
	logic [3:0]        spiMeta_q, spiSync_q;
	logic [1:0]        supMeta_q, supSync_q;
	logic [2*GP_W-1:0] gpMeta_q,  gpSync_q;
	logic              clkS, txS, selS, rxS, hostP, farP, bothOn;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			spiMeta_q <= 4'h4;
			spiSync_q <= 4'h4;
			supMeta_q <= '0;
			supSync_q <= '0;
			gpMeta_q  <= '0;
			gpSync_q  <= '0;
		end else begin
			spiMeta_q <= {farRxIn, hostSelectIn, hostTxIn, hostClockIn};
			spiSync_q <= spiMeta_q;
			supMeta_q <= {farSupply, hostSupply};
			supSync_q <= supMeta_q;
			gpMeta_q  <= {farGpIn, hostGpIn};
			gpSync_q  <= gpMeta_q;
		end
	end

	assign {rxS, selS, txS, clkS} = spiSync_q;
	assign {farP, hostP}          = supSync_q;
	assign bothOn                 = hostP && farP;

	////////////////////////////////////////////////////////////////////////
	// SPI channel gating; levels pass through, no clock recovery
	isg_link_t        lnk_q, lnk_d;
	logic [WAKE_W-1:0] wake_q, wake_d;
	logic             oe_q, oe_d;
	logic             farClk_q, farClk_d, farTx_q, farTx_d, hostRx_q, hostRx_d, farSel_q, farSel_d;

	always_comb begin
		lnk_d    = lnk_q;
		wake_d   = wake_q;
		oe_d     = 1'b0;
		farClk_d = 1'b0;
		farTx_d  = 1'b0;
		hostRx_d = 1'b0;
		farSel_d = selS;
		case (lnk_q)
			LNK_SLEEP: begin
				wake_d = '0;
				if (!selS) begin
					lnk_d = LNK_WAKE;
				end
			end
			LNK_WAKE: begin
				if (selS) begin
					lnk_d = LNK_SLEEP;
				end else if (wake_q == WAKE_W'(WAKE_CYC - 1)) begin
					lnk_d = LNK_ACTIVE;
				end else begin
					wake_d = WAKE_W'(wake_q + 1'b1);
				end
			end
			LNK_ACTIVE: begin
				if (selS) begin
					lnk_d = LNK_SLEEP;
				end else begin
					oe_d     = 1'b1;
					farClk_d = clkS;
					farTx_d  = txS;
					hostRx_d = rxS;
				end
			end
			default: lnk_d = LNK_SLEEP;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			lnk_q    <= LNK_SLEEP;
			wake_q   <= '0;
			oe_q     <= 1'b0;
			farClk_q <= 1'b0;
			farTx_q  <= 1'b0;
			hostRx_q <= 1'b0;
			farSel_q <= 1'b1;
		end else begin
			lnk_q    <= lnk_d;
			wake_q   <= wake_d;
			oe_q     <= oe_d;
			farClk_q <= farClk_d;
			farTx_q  <= farTx_d;
			hostRx_q <= hostRx_d;
			farSel_q <= farSel_d;
		end
	end

	assign farClockOut  = farClk_q;
	assign farTxOut     = farTx_q;
	assign hostRxOut    = hostRx_q;
	assign farClockOe   = oe_q;
	assign farTxOe      = oe_q;
	assign hostRxOe     = oe_q;
	assign farSelectOut = farSel_q;

	sequence s_selFall;
		$fell(selS);
	endsequence
	// Run of low select samples, saturating; a counter keeps the wake bound cheap to check
	localparam int RUN_MAX = WAKE_CYC + 2;                        // Wake count, state step, output flop
	localparam int RUN_W   = $clog2(RUN_MAX + 1);
	logic [RUN_W-1:0] lowRun_q, lowRun_d;

	always_comb begin
		lowRun_d = selS ? '0 : lowRun_q;
		if (!selS && lowRun_q != RUN_W'(RUN_MAX)) begin
			lowRun_d = RUN_W'(lowRun_q + 1'b1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			lowRun_q <= '0;
		end else begin
			lowRun_q <= lowRun_d;
		end
	end

	a_select_sleep: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(selS) |=> (!oe_q && farSel_q)) else $error("outputs not tristated after select rise");
	a_wake_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_selFall |=> (!oe_q) [*8]) else $error("far outputs active during wake latency");
	a_wake_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
		(lowRun_q == RUN_W'(RUN_MAX)) |-> oe_q) else $error("far outputs not active after wake latency");
	a_clock_forward: assert property (@(posedge core_clk) disable iff (!rst_b)
		(lnk_q == LNK_ACTIVE && !selS) |=> (farClk_q == $past(clkS) && farTx_q == $past(txS)))
		else $error("clock or transmit not forwarded");
	a_rx_forward: assert property (@(posedge core_clk) disable iff (!rst_b)
		(lnk_q == LNK_ACTIVE && !selS) |=> (hostRx_q == $past(rxS) && !farSel_q))
		else $error("receive data not forwarded");

	////////////////////////////////////////////////////////////////////////
	// General channels: sampler, packet buffer, single-coil shifter
	isg_fifo_if #(.WIDTH(PKT_W)) pktIf ();

	isg_fifo #(
		.WIDTH (PKT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk  (core_clk),
		.rstB (rst_b),
		.port (pktIf.store)
	);

	logic [SMP_W-1:0]   smpCnt_q, smpCnt_d;
	logic               dir_q, dir_d, pendV_q, pendV_d, smpTick;
	logic [PKT_W-1:0]   pend_q, pend_d;
	logic [BIT_W-1:0]   bitCnt_q, bitCnt_d;
	logic               bitTick;
	isg_tx_t            tx_q, tx_d;
	logic [FRAME_W-1:0] txSh_q, txSh_d, rxSh_q, rxSh_d, rxNew;
	logic [FCNT_W-1:0]  txCnt_q, txCnt_d, rxCnt_q, rxCnt_d;
	logic               coil_q, coil_d, rxDeliver, seenBoth_q, seenBoth_d;
	logic [GP_W-1:0]    hostGp_q, hostGp_d, farGp_q, farGp_d;

	assign smpTick       = (smpCnt_q == SMP_W'(SMP_CYC - 1));
	assign bitTick       = (bitCnt_q == BIT_W'(BIT_CYC - 1));
	assign pktIf.wrData  = pend_q;
	assign pktIf.wrValid = pendV_q;
	assign pktIf.rdReady = (tx_q == TX_IDLE);
	assign rxNew         = {rxSh_q[FRAME_W-2:0], coil_q};

	always_comb begin
		smpCnt_d = smpTick ? '0 : SMP_W'(smpCnt_q + 1'b1);
		bitCnt_d = bitTick ? '0 : BIT_W'(bitCnt_q + 1'b1);
		dir_d    = dir_q;
		pend_d   = pend_q;
		pendV_d  = pendV_q && !pktIf.wrReady;                     // Stalled word waits
		// Whole side captured at one instant, sides alternate
		if (smpTick && bothOn && !pendV_d) begin
			pendV_d = 1'b1;
			pend_d  = {dir_q, (dir_q == DIR_TO_FAR) ? gpSync_q[GP_W-1:0] : gpSync_q[2*GP_W-1:GP_W]};
			dir_d   = !dir_q;
		end
		tx_d    = tx_q;
		txSh_d  = txSh_q;
		txCnt_d = txCnt_q;
		coil_d  = coil_q;
		case (tx_q)
			TX_IDLE: begin
				if (pktIf.rdValid) begin
					txSh_d  = {START_BIT, pktIf.rdData, parityOf(pktIf.rdData)};
					txCnt_d = '0;
					tx_d    = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (bitTick) begin
					coil_d  = txSh_q[FRAME_W-1];
					txSh_d  = {txSh_q[FRAME_W-2:0], COIL_IDLE};
					txCnt_d = FCNT_W'(txCnt_q + 1'b1);
					if (txCnt_q == FCNT_W'(FRAME_W - 1)) begin
						tx_d = TX_GAP;
					end
				end
			end
			TX_GAP: begin
				if (bitTick) begin
					coil_d = COIL_IDLE;                           // Idle bit lets next start be seen
					tx_d   = TX_IDLE;
				end
			end
			default: tx_d = TX_IDLE;
		endcase
		rxSh_d    = rxSh_q;
		rxCnt_d   = rxCnt_q;
		rxDeliver = 1'b0;
		if (bitTick && (rxCnt_q != '0 || coil_q == START_BIT)) begin
			rxSh_d = rxNew;
			if (rxCnt_q == FCNT_W'(FRAME_W - 1)) begin
				rxCnt_d   = '0;
				rxDeliver = bothOn && (parityOf(rxNew[FRAME_W-2:1]) == rxNew[0]);
			end else begin
				rxCnt_d = FCNT_W'(rxCnt_q + 1'b1);
			end
		end
		// Startup ends once both supplies came up; restarts when both are gone
		seenBoth_d = (seenBoth_q || bothOn) && (hostP || farP);
		hostGp_d   = hostGp_q;
		farGp_d    = farGp_q;
		if (rxDeliver && rxNew[FRAME_W-2] == DIR_TO_FAR) begin
			farGp_d = rxNew[FRAME_W-3:1];
		end
		if (rxDeliver && rxNew[FRAME_W-2] == DIR_TO_HOST) begin
			hostGp_d = rxNew[FRAME_W-3:1];
		end
		if (!hostP || !seenBoth_q) begin
			hostGp_d = '0;
		end
		if (!farP || !seenBoth_q) begin
			farGp_d = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			smpCnt_q   <= '0;
			bitCnt_q   <= '0;
			dir_q      <= DIR_TO_FAR;
			pend_q     <= '0;
			pendV_q    <= 1'b0;
			tx_q       <= TX_IDLE;
			txSh_q     <= '0;
			txCnt_q    <= '0;
			coil_q     <= COIL_IDLE;
			rxSh_q     <= '0;
			rxCnt_q    <= '0;
			seenBoth_q <= 1'b0;
			hostGp_q   <= '0;
			farGp_q    <= '0;
		end else begin
			smpCnt_q   <= smpCnt_d;
			bitCnt_q   <= bitCnt_d;
			dir_q      <= dir_d;
			pend_q     <= pend_d;
			pendV_q    <= pendV_d;
			tx_q       <= tx_d;
			txSh_q     <= txSh_d;
			txCnt_q    <= txCnt_d;
			coil_q     <= coil_d;
			rxSh_q     <= rxSh_d;
			rxCnt_q    <= rxCnt_d;
			seenBoth_q <= seenBoth_d;
			hostGp_q   <= hostGp_d;
			farGp_q    <= farGp_d;
		end
	end

	assign hostGpOut = hostGp_q;
	assign farGpOut  = farGp_q;

	a_startup_low: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!bothOn && !seenBoth_q) |=> (hostGp_q == '0 && farGp_q == '0)) else $error("outputs not low in startup");
	a_far_loss_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		(seenBoth_q && hostP && !farP) |=> (hostGp_q == $past(hostGp_q) && farGp_q == '0))
		else $error("far supply loss handled wrongly");
	a_host_loss_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		(seenBoth_q && farP && !hostP) |=> (farGp_q == $past(farGp_q) && hostGp_q == '0))
		else $error("host supply loss handled wrongly");
	a_packet_only: assert property (@(posedge core_clk) disable iff (!rst_b)
		(bothOn && seenBoth_q && !rxDeliver) |=> ($stable(hostGp_q) && $stable(farGp_q)))
		else $error("outputs changed without a packet");
	a_pack_start: assert property (@(posedge core_clk) disable iff (!rst_b)
		(pktIf.rdValid && tx_q == TX_IDLE) |=> (tx_q == TX_SHIFT && txSh_q[FRAME_W-1] == START_BIT))
		else $error("packet not loaded for shifting");
	a_stall_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
		(pendV_q && !pktIf.wrReady) |=> (pendV_q && $stable(pend_q))) else $error("stalled sample lost");
	a_sample_gap: assert property (@(posedge core_clk) disable iff (!rst_b)
		smpTick |=> (!smpTick) [*8]) else $error("sample instants too close");
endmodule // isg_spi_gpio_top

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import isg_pkg::*;
	logic                core_clk, rst_b, hostClockIn, hostTxIn, hostSelectIn, farRxIn;
	logic                hostRxOut, hostRxOe, farClockOut, farClockOe, farTxOut, farTxOe, farSelectOut;
	logic                hostSupply, farSupply;
	logic [GP_WIDTH-1:0] hostGpIn, farGpIn, hostGpOut, farGpOut;
	logic [7:0]          replyByte, slaveByte;
	int                  err_total, samples_checked;
	// External pulls on tristated lines
	wire farClockLine = farClockOe ? farClockOut : 1'h0;
	wire farTxLine    = farTxOe ? farTxOut : 1'h0;
	wire hostRxLine   = hostRxOe ? hostRxOut : 1'h1;

	isg_spi_gpio_top #(.GP_W(GP_WIDTH)) dut_u (.core_clk(core_clk), .rst_b(rst_b), .hostClockIn(hostClockIn),
		.hostTxIn(hostTxIn), .hostSelectIn(hostSelectIn), .hostRxOut(hostRxOut), .hostRxOe(hostRxOe),
		.farClockOut(farClockOut), .farClockOe(farClockOe), .farTxOut(farTxOut), .farTxOe(farTxOe),
		.farSelectOut(farSelectOut), .farRxIn(farRxIn), .hostGpIn(hostGpIn), .farGpIn(farGpIn),
		.hostGpOut(hostGpOut), .farGpOut(farGpOut), .hostSupply(hostSupply), .farSupply(farSupply));
	isg_far_slave slave_u (.farSclk(farClockLine), .farSelB(farSelectOut), .farMosi(farTxLine),
		.farMiso(farRxIn), .replyByte(replyByte), .rxByte(slaveByte));

	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_idle;
		for (int k = 0; k < 6; k++) begin
			hostClockIn = ~hostClockIn;
			step(4);
			chk("farClockLine", 8'h00, 8'(farClockLine));
			chk("farSelectOut", 8'h01, 8'(farSelectOut));
		end
		$display("t_idle done");
	endtask
	task automatic t_wake;
		hostClockIn = 1'h1;
		step(2);
		hostSelectIn = 1'h0;
		for (int k = 0; k < WAKE_CYC; k++) begin
			step(1);
			chk("farClockOe", 8'h00, 8'(farClockOe));
		end
		chk("farSelectOut", 8'h00, 8'(farSelectOut));
		step(6);
		chk("farClockLine", 8'h01, 8'(farClockLine));
		hostClockIn = 1'h0;
		step(4);
		chk("farClockLine", 8'h00, 8'(farClockLine));
		hostSelectIn = 1'h1;
		step(4);
		chk("farClockOe", 8'h00, 8'(farClockOe));
		$display("t_wake done");
	endtask
	task automatic t_xfer(input logic [7:0] txB, input logic [7:0] rep);
		logic [7:0] rxB;
		replyByte    = rep;
		hostTxIn     = txB[7];
		hostSelectIn = 1'h0;
		step(WAKE_CYC + 6);
		for (int i = 7; i >= 0; i--) begin
			hostClockIn = 1'h1;
			step(4); // 80 ns period, below the supported rate
			hostClockIn = 1'h0;
			// Sample late: returned data lags by the round trip
			step(2);
			rxB[i] = hostRxLine;
			if (i > 0) hostTxIn = txB[i-1];
			step(2);
		end
		step(4);
		chk("slaveByte", txB, slaveByte);
		chk("hostRxByte", rep, rxB);
		hostSelectIn = 1'h1;
		step(4);
		chk("farSelectOut", 8'h01, 8'(farSelectOut));
		chk("hostRxLine", 8'h01, 8'(hostRxLine));
		chk("farTxOe", 8'h00, 8'(farTxOe));
		$display("t_xfer %h done", txB);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic wait_gp(input logic [GP_WIDTH-1:0] eh, ef, oh, of);
		int n;
		n = 0;
		while (!(hostGpOut === eh && farGpOut === ef) && n < 3000) begin
			step(1);
			n++;
			if (hostGpOut !== eh && hostGpOut !== oh) chk("hostGpMid", 8'(eh), 8'(hostGpOut));
			if (farGpOut !== ef && farGpOut !== of) chk("farGpMid", 8'(ef), 8'(farGpOut));
		end
		chk("hostGpOut", 8'(eh), 8'(hostGpOut));
		chk("farGpOut", 8'(ef), 8'(farGpOut));
	endtask
	task automatic chk_gp(input logic [GP_WIDTH-1:0] eh, ef);
		chk("hostGpOut", 8'(eh), 8'(hostGpOut));
		chk("farGpOut", 8'(ef), 8'(farGpOut));
	endtask
	task automatic t_gp_start;
		farSupply = 1'h1;
		step(2500);
		chk_gp(3'h0, 3'h0);
		farSupply  = 1'h0;
		hostSupply = 1'h1;
		step(2500);
		chk_gp(3'h0, 3'h0);
		farSupply = 1'h1; // Both rails up for normal running
		wait_gp(3'h2, 3'h5, 3'h0, 3'h0);
		$display("t_gp_start done");
	endtask
	task automatic t_gp_follow;
		hostGpIn = 3'h7;
		farGpIn  = 3'h0;
		wait_gp(3'h0, 3'h7, 3'h2, 3'h5);
		hostGpIn = 3'h3;
		farGpIn  = 3'h4;
		wait_gp(3'h4, 3'h3, 3'h0, 3'h7);
		$display("t_gp_follow done");
	endtask
	task automatic t_gp_drop;
		farSupply = 1'h0;
		step(4);
		chk_gp(3'h4, 3'h0);
		farGpIn = 3'h1;
		step(2500);
		chk_gp(3'h4, 3'h0);
		hostSupply = 1'h0;
		step(4);
		chk_gp(3'h0, 3'h0);
		hostSupply = 1'h1;
		farSupply  = 1'h1;
		wait_gp(3'h1, 3'h3, 3'h0, 3'h0);
		hostSupply = 1'h0;
		step(4);
		chk_gp(3'h0, 3'h3);
		hostGpIn = 3'h6;
		step(2500);
		chk_gp(3'h0, 3'h3);
		$display("t_gp_drop done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		err_total       = 0;
		samples_checked = 0;
		rst_b           = 1'h0;
		hostClockIn     = 1'h0;
		hostTxIn        = 1'h0;
		hostSelectIn    = 1'h1;
		hostGpIn        = 3'h5;
		farGpIn         = 3'h2;
		hostSupply      = 1'h0;
		farSupply       = 1'h0;
		replyByte       = 8'h00;
		repeat (12) @(posedge core_clk);
		#1;
		rst_b = 1'h1;
		step(2);
		t_idle;
		t_wake;
		t_xfer(8'ha5, 8'h3c);
		t_xfer(8'h5a, 8'hc3);
		t_gp_start;
		t_gp_follow;
		t_gp_drop;
		final_report;
	end
	// Whole run needs about 18500 cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		final_report;
	end
endmodule // tb_top
